// ==== nbf_pkg.sv ====
package nbf_pkg;
	localparam logic [31:0] NBF_ARG_OFS = 32'h0000_0008;
	localparam logic [31:0] NBF_REQ_OFS = 32'h0000_0004;
	localparam logic [31:0] NBF_STAT_OFS = 32'h0000_000c;
	localparam logic [7:0] NBF_FIRST_KEY = 8'hb6;
	localparam logic [7:0] NBF_KEY_PROG = 8'hdb;
	localparam logic [7:0] NBF_KEY_WRITE = 8'hda;
	localparam logic [7:0] NBF_KEY_RESUME = 8'hdc;
	localparam logic [15:0] NBF_OP_WRITE = 16'h0007;
	localparam logic [15:0] NBF_OP_PROG = 16'h0008;
	localparam logic [15:0] NBF_OP_RESUME = 16'h0009;
	localparam int NBF_REQ_BIT = 31;
	localparam logic [31:0] NBF_ST_OK = 32'ha000_0000;
	localparam logic [31:0] NBF_ST_RESUME_DONE = 32'hf000_0007;
	localparam logic [31:0] NBF_ST_PENDING = 32'hf000_0008;
	localparam logic [31:0] NBF_ST_BUSY = 32'hf000_0009;
	localparam logic [31:0] NBF_ST_BAD_OP = 32'hf000_000b;
	localparam logic [31:0] NBF_ST_KEY_MISMATCH = 32'hf000_000c;
	localparam logic [31:0] NBF_ARG_RESET = 32'h0000_0000;
	localparam logic [31:0] NBF_REQ_RESET = 32'h0000_0000;
	localparam int NBF_CLK_MHZ = 100;
	localparam int NBF_PHASE_US = 20;
	localparam int NBF_PHASE_CYC = NBF_PHASE_US * NBF_CLK_MHZ;
	localparam logic [15:0] NBF_PHASE_CYC_W = 16'(NBF_PHASE_CYC);
	localparam logic [1:0] NBF_RESP_OKAY = 2'h0;
	localparam logic [1:0] NBF_RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		NBF_IDLE = 3'b000,
		NBF_FETCH = 3'b001,
		NBF_WAIT = 3'b010,
		NBF_DECIDE = 3'b011,
		NBF_RUN = 3'b100
	} nbf_state_t;
endpackage

// ==== nbf_phase_timer.sv ====
`timescale 1ns/1ps
module nbf_phase_timer (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_start,
	output logic o_done
);
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic busy_r;
	logic busy_nxt;
	logic done_r;
	logic done_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		if (i_start) begin
			cnt_nxt = nbf_pkg::NBF_PHASE_CYC_W - 16'h0001;
			busy_nxt = 1'b1;
		end else if (busy_r) begin
			if (cnt_r == 16'h0000) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r - 16'h0001;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_r <= 16'h0000;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign o_done = done_r;
endmodule

// ==== nbf_syscall.sv ====
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - A program-row request runs as a single program phase, with no pre-program or erase phase.
// - Resume finishes remaining phases: three resumes after write row, one after program row.
// - While a phase sequence is unfinished, every call other than resume is refused.
// - The argument register holds the byte address of the parameter word; it is fetched there with the low two bits cleared.
// - Program row is opcode 0x0008 with the request bit set in the top half of the request word.
// - Resume uses the resume key in its parameter word and opcode 0x0009 with the request bit.
// - Firmware runs from SRAM during programming; the block never stalls the processor.
// - Each finished phase raises the supervisory controller interrupt pulse.
// - Every call ends by overwriting the argument register with a status word.
// - A non-resume call while an operation is pending fails with status 0xF0000008.
// - An opcode that does not match its keys fails with status 0xF000000C.
module nbf_syscall (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] o_sram_addr,
	output logic o_sram_rd,
	input wire logic [31:0] i_sram_rdata,
	input wire logic i_sram_rvalid,
	output logic o_flash_start,
	output logic [15:0] o_flash_row,
	output logic o_flash_busy,
	output logic o_phase_irq
);
	nbf_pkg::nbf_state_t st_r, st_nxt;
	logic [31:0] arg_r, arg_nxt;
	logic [31:0] req_r, req_nxt;
	logic [1:0] left_r, left_nxt;
	logic [31:0] param_r, param_nxt;
	logic [31:0] sram_addr_r, sram_addr_nxt;
	logic sram_rd_r, sram_rd_nxt;
	logic fstart_r, fstart_nxt;
	logic [15:0] row_r, row_nxt;
	logic irq_r, irq_nxt;
	logic run_r, run_nxt;
	logic aw_have_r, aw_have_nxt;
	logic w_have_r, w_have_nxt;
	logic [31:0] aw_addr_r, aw_addr_nxt;
	logic [31:0] w_data_r, w_data_nxt;
	logic [3:0] w_strb_r, w_strb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic phase_done;
	logic pending;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	nbf_phase_timer u_timer (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_start(fstart_r),
		.o_done(phase_done)
	);

	// Any unfinished phase counts as pending, even the one now running
	assign pending = (left_r != 2'd0) || run_r;

	always_comb begin
		logic do_wr;
		logic [31:0] wv;
		do_wr = 1'b0;
		wv = 32'h0000_0000;
		st_nxt = st_r;
		arg_nxt = arg_r;
		req_nxt = req_r;
		left_nxt = left_r;
		param_nxt = param_r;
		sram_addr_nxt = sram_addr_r;
		sram_rd_nxt = 1'b0;
		fstart_nxt = 1'b0;
		row_nxt = row_r;
		irq_nxt = 1'b0;
		run_nxt = run_r;
		// Phase end seen in any state, so calls are serviced meanwhile
		if (phase_done) begin
			run_nxt = 1'b0;
			irq_nxt = 1'b1;
		end
		aw_have_nxt = aw_have_r;
		w_have_nxt = w_have_r;
		aw_addr_nxt = aw_addr_r;
		w_data_nxt = w_data_r;
		w_strb_nxt = w_strb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_awvalid && !aw_have_r) begin
			aw_have_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_have_r) begin
			w_have_nxt = 1'b1;
			w_data_nxt = s_axi_wdata;
			w_strb_nxt = s_axi_wstrb;
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (aw_have_r && w_have_r && !bvalid_r) begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = nbf_pkg::NBF_RESP_OKAY;
			wv = merge(32'h0000_0000, w_data_r, w_strb_r);
			if (aw_addr_r[11:2] == nbf_pkg::NBF_ARG_OFS[11:2]) begin
				// Argument is locked while a call is being serviced
				if (!req_r[nbf_pkg::NBF_REQ_BIT]) begin
					arg_nxt = merge(arg_r, w_data_r, w_strb_r);
				end
			end else if (aw_addr_r[11:2] == nbf_pkg::NBF_REQ_OFS[11:2]) begin
				if (!req_r[nbf_pkg::NBF_REQ_BIT]) begin
					req_nxt = merge(req_r, w_data_r, w_strb_r);
					do_wr = wv[nbf_pkg::NBF_REQ_BIT];
				end
			end else if (aw_addr_r[11:2] != nbf_pkg::NBF_STAT_OFS[11:2]) begin
				bresp_nxt = nbf_pkg::NBF_RESP_SLVERR;
			end
		end
		if (s_axi_arvalid && !rvalid_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = nbf_pkg::NBF_RESP_OKAY;
			if (s_axi_araddr[11:2] == nbf_pkg::NBF_ARG_OFS[11:2]) begin
				rdata_nxt = arg_r;
			end else if (s_axi_araddr[11:2] == nbf_pkg::NBF_REQ_OFS[11:2]) begin
				rdata_nxt = req_r;
			end else if (s_axi_araddr[11:2] == nbf_pkg::NBF_STAT_OFS[11:2]) begin
				rdata_nxt = {28'h0, left_r, pending, (st_r != nbf_pkg::NBF_IDLE)};
			end else begin
				rdata_nxt = 32'h0000_0000;
				rresp_nxt = nbf_pkg::NBF_RESP_SLVERR;
			end
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		case (st_r)
			nbf_pkg::NBF_IDLE: begin
				if (do_wr || req_r[nbf_pkg::NBF_REQ_BIT]) begin
					st_nxt = nbf_pkg::NBF_FETCH;
				end
			end
			nbf_pkg::NBF_FETCH: begin
				sram_addr_nxt = {arg_r[31:2], 2'b00};
				sram_rd_nxt = 1'b1;
				st_nxt = nbf_pkg::NBF_WAIT;
			end
			nbf_pkg::NBF_WAIT: begin
				if (i_sram_rvalid) begin
					param_nxt = i_sram_rdata;
					st_nxt = nbf_pkg::NBF_DECIDE;
				end
			end
			nbf_pkg::NBF_DECIDE: begin
				st_nxt = run_nxt ? nbf_pkg::NBF_RUN : nbf_pkg::NBF_IDLE;
				req_nxt[nbf_pkg::NBF_REQ_BIT] = 1'b0;
				if (req_r[15:0] != nbf_pkg::NBF_OP_RESUME && pending) begin
					arg_nxt = nbf_pkg::NBF_ST_PENDING;
				end else if (req_r[15:0] != nbf_pkg::NBF_OP_PROG
					&& req_r[15:0] != nbf_pkg::NBF_OP_WRITE
					&& req_r[15:0] != nbf_pkg::NBF_OP_RESUME) begin
					arg_nxt = nbf_pkg::NBF_ST_BAD_OP;
				end else if (param_r[7:0] != nbf_pkg::NBF_FIRST_KEY
					|| (req_r[15:0] == nbf_pkg::NBF_OP_PROG
					&& param_r[15:8] != nbf_pkg::NBF_KEY_PROG)
					|| (req_r[15:0] == nbf_pkg::NBF_OP_WRITE
					&& param_r[15:8] != nbf_pkg::NBF_KEY_WRITE)
					|| (req_r[15:0] == nbf_pkg::NBF_OP_RESUME
					&& param_r[15:8] != nbf_pkg::NBF_KEY_RESUME)) begin
					arg_nxt = nbf_pkg::NBF_ST_KEY_MISMATCH;
				end else if (req_r[15:0] == nbf_pkg::NBF_OP_RESUME) begin
					if (left_r == 2'd0) begin
						arg_nxt = nbf_pkg::NBF_ST_RESUME_DONE;
					end else begin
						// Success is written when the resume call is accepted
						left_nxt = left_r - 2'd1;
						arg_nxt = nbf_pkg::NBF_ST_OK;
						if (left_r != 2'd1) begin
							fstart_nxt = 1'b1;
							run_nxt = 1'b1;
							st_nxt = nbf_pkg::NBF_RUN;
						end
					end
				end else begin
					row_nxt = param_r[31:16];
					fstart_nxt = 1'b1;
					run_nxt = 1'b1;
					st_nxt = nbf_pkg::NBF_RUN;
					arg_nxt = nbf_pkg::NBF_ST_OK;
					// Program row is one phase, write row three
					if (req_r[15:0] == nbf_pkg::NBF_OP_PROG) begin
						left_nxt = 2'd1;
					end else begin
						left_nxt = 2'd3;
					end
				end
			end
			nbf_pkg::NBF_RUN: begin
				// Processor keeps running from SRAM; no stall path
				if (req_r[nbf_pkg::NBF_REQ_BIT]) begin
					st_nxt = nbf_pkg::NBF_FETCH;
				end else if (!run_r) begin
					st_nxt = nbf_pkg::NBF_IDLE;
				end
			end
			default: begin
				st_nxt = nbf_pkg::NBF_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_r <= nbf_pkg::NBF_IDLE;
			arg_r <= nbf_pkg::NBF_ARG_RESET;
			req_r <= nbf_pkg::NBF_REQ_RESET;
			left_r <= 2'd0;
			param_r <= 32'h0000_0000;
			sram_addr_r <= 32'h0000_0000;
			sram_rd_r <= 1'b0;
			fstart_r <= 1'b0;
			row_r <= 16'h0000;
			irq_r <= 1'b0;
			run_r <= 1'b0;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 32'h0000_0000;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= 2'h0;
		end else begin
			st_r <= st_nxt;
			arg_r <= arg_nxt;
			req_r <= req_nxt;
			left_r <= left_nxt;
			param_r <= param_nxt;
			sram_addr_r <= sram_addr_nxt;
			sram_rd_r <= sram_rd_nxt;
			fstart_r <= fstart_nxt;
			row_r <= row_nxt;
			irq_r <= irq_nxt;
			run_r <= run_nxt;
			aw_have_r <= aw_have_nxt;
			w_have_r <= w_have_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	logic busy_out_r;
	logic awready_r;
	logic wready_r;
	logic arready_r;
	// Readies taken from next holding state so every output leaves a flop
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			busy_out_r <= 1'b0;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			arready_r <= 1'b1;
		end else begin
			busy_out_r <= run_nxt;
			awready_r <= !aw_have_nxt;
			wready_r <= !w_have_nxt;
			arready_r <= !rvalid_nxt;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign o_sram_addr = sram_addr_r;
	assign o_sram_rd = sram_rd_r;
	assign o_flash_start = fstart_r;
	assign o_flash_row = row_r;
	assign o_flash_busy = busy_out_r;
	assign o_phase_irq = irq_r;
endmodule

// ==== nbf_syscall_props.sv ====
`timescale 1ns/1ps
module nbf_syscall_props (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [31:0] o_sram_addr,
	input wire logic o_sram_rd,
	input wire logic o_flash_start,
	input wire logic o_flash_busy,
	input wire logic o_phase_irq
);
	// Busy also covers the start edge and the edge that sees the timer end
	localparam int MAX_BUSY = nbf_pkg::NBF_PHASE_CYC + 2;
	logic [11:0] busy_r;
	logic [11:0] busy_nxt;
	always_comb begin
		busy_nxt = o_flash_busy ? busy_r + 12'h001 : 12'h000;
	end
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			busy_r <= 12'h000;
		end else begin
			busy_r <= busy_nxt;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	chk_phase_bound: assert property (busy_r <= MAX_BUSY)
		else $error("phase ran too long");
	chk_phase_len: assert property (o_phase_irq |-> busy_r == 12'(MAX_BUSY))
		else $error("phase length wrong");
	chk_start_busy: assert property (o_flash_start |=> o_flash_busy)
		else $error("start without busy");
	chk_start_single: assert property (o_flash_start |=> !o_flash_start)
		else $error("start not a pulse");
	chk_irq_pulse: assert property (o_phase_irq |=> !o_phase_irq && !o_flash_busy)
		else $error("irq not a single end pulse");
	chk_irq_after_busy: assert property (o_phase_irq |-> $past(o_flash_busy))
		else $error("irq without a phase");
	chk_fetch_aligned: assert property (o_sram_rd |-> o_sram_addr[1:0] == 2'h0 ##1 !o_sram_rd)
		else $error("fetch misaligned or long");
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	cover property (o_phase_irq);
	cover property (o_sram_rd);
	cover property (s_axi_rvalid && s_axi_rdata == 32'hf000_0008);
endmodule
bind nbf_syscall nbf_syscall_props i_props (.i_clk, .i_reset_n, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .o_sram_addr, .o_sram_rd,
	.o_flash_start, .o_flash_busy, .o_phase_irq);

// ==== nbf_sram_model.sv ====
`timescale 1ns/1ps
module nbf_sram_model (
	input wire logic i_clk,
	input wire logic i_rd,
	input wire logic [31:0] i_addr,
	input wire logic [3:0] i_lat,
	output logic [31:0] o_rdata,
	output logic o_rvalid
);
	logic [31:0] mem [0:15];
	logic [5:0] adr_r;
	int cnt;
	initial begin
		o_rvalid = 1'b0;
		o_rdata = 32'h0000_0000;
		cnt = -1;
	end
	// Idle data toggles so a stale word never passes
	always @(posedge i_clk) begin
		o_rvalid <= 1'b0;
		o_rdata <= ~o_rdata;
		if (i_rd) begin
			adr_r <= i_addr[5:0];
			cnt <= i_lat;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end else if (cnt == 0) begin
			o_rvalid <= 1'b1;
			o_rdata <= mem[adr_r[5:2]];
			cnt <= -1;
		end
	end
endmodule

// ==== tb_nonblocking_flash_syscall.sv ====
`timescale 1ns/1ps
module tb_nonblocking_flash_syscall;
	logic i_clk, i_reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic o_sram_rd, i_sram_rvalid, o_flash_start, o_flash_busy, o_phase_irq;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, o_sram_addr, i_sram_rdata;
	logic [31:0] rv;
	logic [3:0] s_axi_wstrb, lat;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic [15:0] o_flash_row, row;
	int n_mismatch, n_checks, n_start, n_irq, left;
	nbf_syscall i_dut (.i_clk, .i_reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .o_sram_addr, .o_sram_rd, .i_sram_rdata,
		.i_sram_rvalid, .o_flash_start, .o_flash_row, .o_flash_busy, .o_phase_irq);
	nbf_sram_model i_sram (.i_clk, .i_rd(o_sram_rd), .i_addr(o_sram_addr), .i_lat(lat),
		.o_rdata(i_sram_rdata), .o_rvalid(i_sram_rvalid));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (o_flash_start) n_start++;
		if (o_phase_irq) n_irq++;
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic bad(input string m);
		n_mismatch++;
		$display("unexpected at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) bad($sformatf("got %h want %h", g, e));
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (n > 100) begin
				bad("write hang");
				complete_run;
			end
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, 32'h0);
	endtask
	task automatic rd(input logic [31:0] a);
		int n;
		n = 0;
		@(posedge i_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (n > 100) begin
				bad("read hang");
				complete_run;
			end
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		rv = s_axi_rdata;
		rr = s_axi_rresp;
	endtask
	function automatic logic [31:0] mdl(input logic [15:0] op, input logic [15:0] k);
		if (op != 16'h9 && left > 0) return 32'hf000_0008;
		if (op < 16'h7 || op > 16'h9) return 32'hf000_000b;
		if (k != {8'hd3 + op[7:0], 8'hb6}) return 32'hf000_000c;
		if (op == 16'h9) begin
			if (left == 0) return 32'hf000_0007;
			left--;
			return 32'ha000_0000;
		end
		left = (op == 16'h8) ? 1 : 3;
		return 32'ha000_0000;
	endfunction
	task automatic call(input logic [15:0] op, input logic [15:0] k);
		logic [31:0] adr;
		logic [31:0] ex;
		int n;
		adr = {24'h200000, 2'b00, 4'($urandom), 2'b00};
		i_sram.mem[adr[5:2]] = {row, k};
		lat <= 4'($urandom % 4);
		ex = mdl(op, k);
		wr(nbf_pkg::NBF_ARG_OFS, adr);
		// Request only once the argument register holds the parameter address
		wr(nbf_pkg::NBF_REQ_OFS, {16'h8000, op});
		n = 0;
		do begin
			rd(nbf_pkg::NBF_REQ_OFS);
			n++;
			if (n > 50) bad("request stuck");
		end while (rv[31] && n <= 50);
		rd(nbf_pkg::NBF_ARG_OFS);
		chk(rv, ex);
	endtask
	task automatic wait_irq(input int k);
		int n;
		for (n = 0; n_irq < k; n++) begin
			@(posedge i_clk);
			if (n > 3000) begin
				bad("no phase end");
				complete_run;
			end
		end
	endtask
	initial begin
		{i_reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, lat, n_start, n_irq, left} = '0;
		s_axi_wstrb = 4'hf;
		void'($urandom(85));
		repeat (16) @(posedge i_clk);
		i_reset_n <= 1'b1;
		rd(nbf_pkg::NBF_REQ_OFS);
		chk(rv, 32'h0);
		rd(32'h0000_0010);
		chk(rr, 32'h2);
		$display("test 1 done");
		row = 16'($urandom);
		call(16'h8, 16'hdbb6);
		chk(o_flash_row, row);
		rd(nbf_pkg::NBF_STAT_OFS);
		chk(rv, 32'h0000_0007);
		call(16'h8, 16'hdbb6);
		wait_irq(1);
		call(16'h9, 16'hdcb6);
		call(16'h9, 16'hdcb6);
		chk(n_start, 1);
		$display("test 2 done");
		call(16'h7, 16'hdab6);
		for (int j = 2; j < 5; j++) begin
			wait_irq(j);
			call(16'h9, 16'hdcb6);
		end
		chk(n_start, 4);
		rd(nbf_pkg::NBF_STAT_OFS);
		chk(rv, 32'h0000_0000);
		$display("test 3 done");
		call(16'h8, 16'hdcb6);
		call(16'h8, 16'hdbb7);
		call(16'h5, 16'hdbb6);
		$display("test 4 done");
		complete_run;
	end
endmodule
